// >>> rtl/spg_six_phase_pwm.sv
`timescale 1ns/1ps
module spg_six_phase_pwm
   import spg_pkg::*;
(
   // clock and reset
   input  wire logic                       clk_sys,
   input  wire logic                       reset_n,
   // register bus
   input  wire spg_axi_req_s               axiReq,
   output spg_axi_rsp_s                    axiRsp,
   // gate drive outputs
   output spg_pwm_s                        pwmOut,
   // events and status
   output logic                            crestIrq,
   output logic                            valleyIrq,
   output logic                            countDirFlag,
   // companion timer compare values
   output logic [1:0][CNT_W-1:0]           companionCompare
);

   spg_state_s s_q;
   spg_state_s s_d;
   logic       rstMeta_q;
   logic       rstSync_q;

   // apply byte enables to a stored word
   function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                              input logic [31:0] newVal,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = oldVal;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = newVal[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // known register offsets
   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      unique case (a)
         OFS_CTRL, OFS_CYCLE, OFS_DUTY_U, OFS_DUTY_V, OFS_DUTY_W, OFS_DEAD,
         OFS_OPT1, OFS_COMP0, OFS_COMP1, OFS_STATUS: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // read view of the register file
   function automatic logic [31:0] readReg(input spg_state_s st,
                                           input logic [ADDR_W-1:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         OFS_CTRL:   v[CTRL_W-1:0] = st.ctrl;
         OFS_CYCLE:  v[CNT_W-1:0]  = st.cycBuf;
         OFS_DUTY_U: v[CNT_W-1:0]  = st.dutyBuf[0];
         OFS_DUTY_V: v[CNT_W-1:0]  = st.dutyBuf[1];
         OFS_DUTY_W: v[CNT_W-1:0]  = st.dutyBuf[2];
         OFS_DEAD:   v[DT_W-1:0]   = st.deadTime;
         OFS_OPT1:   v[OPT_W-1:0]  = st.optBuf;
         OFS_COMP0:  v[CNT_W-1:0]  = st.compBuf[0];
         OFS_COMP1:  v[CNT_W-1:0]  = st.compBuf[1];
         OFS_STATUS: begin
            v[STAT_DIR_BIT]                 = st.dirDown;
            v[STAT_CNT_LSB +: CNT_W]        = st.cnt;
         end
         default:    v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // move every buffered value to its active copy
   function automatic spg_state_s copyBuffers(input spg_state_s st);
      spg_state_s r;
      r          = st;
      r.cycAct   = st.cycBuf;
      r.dutyAct  = st.dutyBuf;
      r.optAct   = st.optBuf;
      r.compAct  = st.compBuf;
      r.xferPend = 1'b0;
      return r;
   endfunction

   // next level of one basic phase wave
   function automatic logic nextWave(input logic             cur,
                                     input logic             atCrest,
                                     input logic             atValley,
                                     input logic [CNT_W-1:0] nextCnt,
                                     input logic             nextDown,
                                     input logic [CNT_W-1:0] duty);
      logic lvl;
      lvl = cur;
      if (atCrest) begin
         lvl = 1'b1;
      end
      if (atValley) begin
         lvl = 1'b0;
      end
      // the match is applied last so it beats a forced edge;
      // duty 0 and cycle+1 only ever match at a turning point
      if (nextCnt == duty) begin
         lvl = ~nextDown;
      end
      return lvl;
   endfunction

   // next dead-time count: a wave edge restarts the gap, zero means idle
   function automatic logic [DT_W-1:0] nextGap(input logic            waveEdge,
                                               input logic [DT_W-1:0] cur,
                                               input logic [DT_W-1:0] dead);
      logic [DT_W-1:0] n;
      n = cur;
      if (waveEdge && dead != '0) begin
         n = 10'h001;
      end else if (cur != '0) begin
         n = (cur >= dead) ? '0 : cur + 10'h001;
      end
      return n;
   endfunction

   // thinning: an enabled event fires once its skip count is used up
   function automatic logic thinFire(input logic              ev,
                                     input logic [THIN_W-1:0] seen,
                                     input logic [THIN_W-1:0] target);
      return ev & (seen == target);
   endfunction

   // skip count after an event, back to zero when the event fires
   function automatic logic [THIN_W-1:0] thinNext(input logic              ev,
                                                   input logic [THIN_W-1:0] seen,
                                                   input logic [THIN_W-1:0] target);
      logic [THIN_W-1:0] nxt;
      nxt = seen;
      if (ev) begin
         nxt = (seen == target) ? '0 : seen + 5'h01;
      end
      return nxt;
   endfunction

   // reset release through two flip-flops
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   always_comb begin
      logic                         run;
      logic                         anytime;
      logic                         crest;
      logic                         valley;
      logic                         xfer;
      logic [PHASES-1:0][CNT_W-1:0] dutyUse;
      logic [31:0]                  wWord;
      logic [THIN_W-1:0]            thinTarget;
      logic                         doWrite;
      logic                         crestEv;
      logic                         valleyEv;
      run        = 1'b0;
      anytime    = 1'b0;
      crest      = 1'b0;
      valley     = 1'b0;
      xfer       = 1'b0;
      dutyUse    = '0;
      wWord      = 32'h0000_0000;
      thinTarget = '0;
      doWrite    = 1'b0;
      crestEv    = 1'b0;
      valleyEv   = 1'b0;
      s_d        = s_q;

      run     = (s_q.ctrl[CTRL_MODE_LSB +: 3] == MODE_SIX_PHASE)
              & s_q.ctrl[CTRL_RUN_BIT];
      anytime = s_q.ctrl[CTRL_ANY_BIT];
      crest   = run & ~s_q.dirDown & (s_q.cnt == s_q.cycAct);
      valley  = run & s_q.dirDown & (s_q.cnt == VALLEY_COUNT);
      xfer    = (crest | valley) & s_q.xferPend & ~anytime;

      // buffered values move to the active side at crest or valley
      if (xfer) begin
         s_d = copyBuffers(s_d);
      end
      dutyUse = s_d.dutyAct;

      // carrier counter
      if (!run) begin
         s_d.cnt     = COUNT_START;
         s_d.dirDown = 1'b0;
      end else begin
         s_d.cnt = s_q.dirDown ? s_q.cnt - 16'h0001 : s_q.cnt + 16'h0001;
         if (crest) begin
            s_d.dirDown = 1'b1;
         end
         if (valley) begin
            s_d.dirDown = 1'b0;
         end
      end

      // basic three-phase wave; matches are taken on the next count
      for (int p = 0; p < PHASES; p++) begin
         s_d.wave[p] = run & nextWave(s_q.wave[p], crest, valley, s_d.cnt, s_d.dirDown,
                                      dutyUse[p]);
      end

      // dead-time insertion per phase
      for (int p = 0; p < PHASES; p++) begin
         s_d.dtCnt[p]   = run ? nextGap(s_d.wave[p] != s_q.wave[p], s_q.dtCnt[p],
                                        s_q.deadTime) : '0;
         s_d.busy[p]    = s_d.dtCnt[p] != '0;
         s_d.pwm.pos[p] = run & s_d.wave[p] & ~s_d.busy[p];
         s_d.pwm.neg[p] = run & ~s_d.wave[p] & ~s_d.busy[p];
      end

      // interrupt thinning: fire on every (count+1)-th event
      thinTarget     = s_q.optAct[OPT_THIN_LSB +: THIN_W];
      crestEv        = crest & s_q.optAct[OPT_CREST_EN];
      valleyEv       = valley & s_q.optAct[OPT_VALLEY_EN];
      s_d.crestIrq   = thinFire(crestEv, s_q.crestThin, thinTarget);
      s_d.valleyIrq  = thinFire(valleyEv, s_q.valleyThin, thinTarget);
      s_d.crestThin  = run ? thinNext(crestEv, s_q.crestThin, thinTarget) : '0;
      s_d.valleyThin = run ? thinNext(valleyEv, s_q.valleyThin, thinTarget) : '0;

      // write channel: address and data taken in either order
      if (axiReq.awvalid && !s_q.awHave && !s_q.bvalid) begin
         s_d.awHave = 1'b1;
         s_d.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && !s_q.wHave && !s_q.bvalid) begin
         s_d.wHave = 1'b1;
         s_d.wData = axiReq.wdata;
         s_d.wStrb = axiReq.wstrb;
      end
      doWrite = s_q.awHave & s_q.wHave & ~s_q.bvalid;
      if (doWrite) begin
         s_d.awHave = 1'b0;
         s_d.wHave  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = isMapped(s_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
         wWord      = mergeBytes(readReg(s_q, s_q.awAddr), s_q.wData, s_q.wStrb);
         unique case (s_q.awAddr)
            OFS_CTRL:   s_d.ctrl          = wWord[CTRL_W-1:0];
            OFS_CYCLE:  s_d.cycBuf        = wWord[CNT_W-1:0];
            OFS_DUTY_U: s_d.dutyBuf[0]    = wWord[CNT_W-1:0];
            OFS_DUTY_V: s_d.dutyBuf[1]    = wWord[CNT_W-1:0];
            OFS_DUTY_W: s_d.dutyBuf[2]    = wWord[CNT_W-1:0];
            OFS_DEAD:   s_d.deadTime      = wWord[DT_W-1:0];
            OFS_OPT1:   s_d.optBuf        = wWord[OPT_W-1:0];
            OFS_COMP0:  s_d.compBuf[0]    = wWord[CNT_W-1:0];
            OFS_COMP1:  s_d.compBuf[1]    = wWord[CNT_W-1:0];
            default:    s_d.bresp         = s_d.bresp;
         endcase
         // duty U write arms the batch transfer; arming beats the crest/valley transfer clear, not the immediate-mode copy
         if (s_q.awAddr == OFS_DUTY_U) begin
            s_d.xferPend = 1'b1;
         end
      end
      // immediate rewrite mode, or nothing running to disturb
      if (anytime || !run) begin
         s_d = copyBuffers(s_d);
      end
      if (s_q.bvalid && axiReq.bready) begin
         s_d.bvalid = 1'b0;
      end

      // read channel
      if (axiReq.arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = readReg(s_q, axiReq.araddr);
         s_d.rresp  = isMapped(axiReq.araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_q.rvalid && axiReq.rready) begin
         s_d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstSync_q) begin
      if (!rstSync_q) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // bus answers
   always_comb begin
      axiRsp         = '0;
      // no request is accepted while the internal reset still holds the state
      axiRsp.awready = ~s_q.awHave & ~s_q.bvalid & rstSync_q;
      axiRsp.wready  = ~s_q.wHave & ~s_q.bvalid & rstSync_q;
      axiRsp.bvalid  = s_q.bvalid;
      axiRsp.bresp   = s_q.bresp;
      axiRsp.arready = ~s_q.rvalid & rstSync_q;
      axiRsp.rvalid  = s_q.rvalid;
      axiRsp.rdata   = s_q.rdata;
      axiRsp.rresp   = s_q.rresp;
   end

   assign pwmOut           = s_q.pwm;
   assign crestIrq         = s_q.crestIrq;
   assign valleyIrq        = s_q.valleyIrq;
   assign countDirFlag     = s_q.dirDown;
   assign companionCompare = s_q.compAct;

endmodule

// >>> common/spg_pkg.sv
package spg_pkg;

   // geometry
   localparam int CNT_W   = 16;
   localparam int DT_W    = 10;
   localparam int PHASES  = 3;
   localparam int ADDR_W  = 6;
   localparam int THIN_W  = 5;
   localparam int OPT_W   = 7;
   localparam int CTRL_W  = 5;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_CYCLE  = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_DUTY_U = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_DUTY_V = 6'h0c;
   localparam logic [ADDR_W-1:0] OFS_DUTY_W = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_DEAD   = 6'h14;
   localparam logic [ADDR_W-1:0] OFS_OPT1   = 6'h18;
   localparam logic [ADDR_W-1:0] OFS_COMP0  = 6'h1c;
   localparam logic [ADDR_W-1:0] OFS_COMP1  = 6'h20;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h24;

   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RUN_BIT  = 3;
   localparam int CTRL_ANY_BIT  = 4;
   localparam logic [2:0] MODE_SIX_PHASE = 3'h7;

   // option register 1 fields
   localparam int OPT_CREST_EN  = 0;
   localparam int OPT_VALLEY_EN = 1;
   localparam int OPT_THIN_LSB  = 2;

   // status register fields
   localparam int STAT_DIR_BIT  = 0;
   localparam int STAT_CNT_LSB  = 16;

   // counter landmarks
   localparam logic [CNT_W-1:0] VALLEY_COUNT = 16'h0001;
   localparam logic [CNT_W-1:0] COUNT_START  = 16'h0000;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } spg_axi_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } spg_axi_rsp_s;

   typedef struct packed {
      logic [PHASES-1:0] pos;
      logic [PHASES-1:0] neg;
   } spg_pwm_s;

   typedef struct packed {
      logic [CTRL_W-1:0]                ctrl;
      logic [CNT_W-1:0]                 cycBuf;
      logic [CNT_W-1:0]                 cycAct;
      logic [PHASES-1:0][CNT_W-1:0]     dutyBuf;
      logic [PHASES-1:0][CNT_W-1:0]     dutyAct;
      logic [DT_W-1:0]                  deadTime;
      logic [OPT_W-1:0]                 optBuf;
      logic [OPT_W-1:0]                 optAct;
      logic [1:0][CNT_W-1:0]            compBuf;
      logic [1:0][CNT_W-1:0]            compAct;
      logic                             xferPend;
      logic [CNT_W-1:0]                 cnt;
      logic                             dirDown;
      logic [PHASES-1:0]                wave;
      logic [PHASES-1:0]                busy;
      logic [PHASES-1:0][DT_W-1:0]      dtCnt;
      spg_pwm_s                         pwm;
      logic [THIN_W-1:0]                crestThin;
      logic [THIN_W-1:0]                valleyThin;
      logic                             crestIrq;
      logic                             valleyIrq;
      logic                             awHave;
      logic [ADDR_W-1:0]                awAddr;
      logic                             wHave;
      logic [31:0]                      wData;
      logic [3:0]                       wStrb;
      logic                             bvalid;
      logic [1:0]                       bresp;
      logic                             rvalid;
      logic [31:0]                      rdata;
      logic [1:0]                       rresp;
   } spg_state_s;

endpackage

// >>> testbench/spg_gate_driver_model.sv
`timescale 1ns/1ps
module spg_gate_driver_model
   import spg_pkg::*;
(
   // clock
   input wire logic     clk_sys,
   // gate commands from the pwm block
   input wire spg_pwm_s gateIn,
   // count of cycles with both switches of a leg on
   output int           shootThru
);
   int hits = 0;

   assign shootThru = hits;

   // a leg with both gates on shorts the supply; looked at once settled
   always @(negedge clk_sys) begin
      if ((gateIn.pos & gateIn.neg) != '0)
         hits <= hits + 1;
   end
endmodule

// >>> testbench/spg_pwm_chk.sv
`timescale 1ns/1ps
module spg_pwm_chk
   import spg_pkg::*;
(
   // clock and reset
   input wire logic                  clk_sys,
   input wire logic                  reset_n,
   // register bus
   input wire spg_axi_req_s          axiReq,
   input wire spg_axi_rsp_s          axiRsp,
   // outputs
   input wire spg_pwm_s              pwmOut,
   input wire logic                  crestIrq,
   input wire logic                  valleyIrq,
   input wire logic                  countDirFlag,
   input wire logic [1:0][CNT_W-1:0] companionCompare
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   a_reset_quiet: assert property (disable iff (1'b0) !reset_n |-> pwmOut == '0)
      else $error("outputs active in reset");
   a_no_overlap: assert property ((pwmOut.pos & pwmOut.neg) == '0)
      else $error("both switches of a leg on");
   a_crest_dir: assert property (crestIrq |-> ##[0:1] countDirFlag)
      else $error("crest event without turn to down count");
   a_valley_dir: assert property (valleyIrq |-> ##[0:1] !countDirFlag)
      else $error("valley event without turn to up count");
   a_crest_space: assert property (crestIrq |=> !crestIrq [*5])
      else $error("crest events too close");
   a_valley_apart: assert property (valleyIrq |-> !crestIrq ##1 !valleyIrq [*5])
      else $error("valley event misplaced");
   a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
      else $error("read answer late");
   a_write_answer: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
      && axiRsp.wready |-> ##2 axiRsp.bvalid)
      else $error("write answer late");
   a_write_busy: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
      else $error("write taken while answer pending");
   a_read_busy: assert property (axiRsp.rvalid |-> !axiRsp.arready)
      else $error("read taken while answer pending");

   c_crest: cover property (crestIrq);
   c_valley: cover property (valleyIrq);
   c_full_on: cover property (pwmOut.pos[0] && !pwmOut.neg[0]);
endmodule

bind spg_six_phase_pwm spg_pwm_chk u_chk (
   .clk_sys(clk_sys), .reset_n(reset_n), .axiReq(axiReq), .axiRsp(axiRsp),
   .pwmOut(pwmOut), .crestIrq(crestIrq), .valleyIrq(valleyIrq),
   .countDirFlag(countDirFlag), .companionCompare(companionCompare));

// >>> testbench/tb_spg_six_phase_pwm.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin nErrors++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module tb_spg_six_phase_pwm
   import spg_pkg::*;
;
   localparam int M = 4;
   localparam int PER = 2 * (M + 1);
   logic              clk_sys = 1'b0;
   logic              reset_n = 1'b1;
   spg_axi_req_s      req = '0;
   spg_axi_rsp_s      rsp;
   spg_pwm_s          pwm;
   logic              crest;
   logic              valley;
   logic              dirFlag;
   logic [1:0][CNT_W-1:0] cmpOut;
   logic [31:0]       rdData;
   logic [1:0]        resp;
   logic [ADDR_W-1:0] dutyOfs [PHASES] = '{OFS_DUTY_U, OFS_DUTY_V, OFS_DUTY_W};
   int                nErrors = 0;
   int                samplesChecked = 0;
   int                shootThru;
   int                hi [PHASES];
   int                lo [PHASES];
   int                per;
   int                nCrest;
   int                nValley;

   always #5 clk_sys = ~clk_sys;

   spg_six_phase_pwm u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .axiReq(req),
      .axiRsp(rsp), .pwmOut(pwm), .crestIrq(crest), .valleyIrq(valley),
      .countDirFlag(dirFlag), .companionCompare(cmpOut));
   spg_gate_driver_model u_drv (.clk_sys(clk_sys), .gateIn(pwm), .shootThru(shootThru));

   task automatic printVerdict();
      $display("checks %0d errors %0d", samplesChecked, nErrors);
      if (nErrors == 0 && samplesChecked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic guard(input logic ok);
      if (!ok) begin
         nErrors++;
         $display("ERROR t=%0t wait timed out", $time);
         printVerdict();
      end
   endtask

   task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      logic awGo, wGo, bGo;
      n = 0;
      bGo = 1'b0;
      @(posedge clk_sys);
      req.awaddr <= a;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      while (!bGo && n < 100) begin
         @(negedge clk_sys);
         awGo = req.awvalid && rsp.awready;
         wGo = req.wvalid && rsp.wready;
         bGo = rsp.bvalid;
         resp = rsp.bresp;
         @(posedge clk_sys);
         if (awGo) req.awvalid <= 1'b0;
         if (wGo) req.wvalid <= 1'b0;
         if (bGo) req.bready <= 1'b0;
         n++;
      end
      guard(bGo);
   endtask

   task automatic axiRead(input logic [ADDR_W-1:0] a);
      int n;
      logic arGo, rGo;
      n = 0;
      rGo = 1'b0;
      @(posedge clk_sys);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      while (!rGo && n < 100) begin
         @(negedge clk_sys);
         arGo = req.arvalid && rsp.arready;
         rGo = rsp.rvalid;
         rdData = rsp.rdata;
         resp = rsp.rresp;
         @(posedge clk_sys);
         if (arGo) req.arvalid <= 1'b0;
         if (rGo) req.rready <= 1'b0;
         n++;
      end
      guard(rGo);
   endtask

   // one carrier period from crest to crest, high cycles per output
   task automatic measure();
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (crest !== 1'b1 && n < 200);
      guard(n < 200);
      per = 0;
      hi = '{default: 0};
      lo = '{default: 0};
      do begin
         @(negedge clk_sys);
         per++;
         for (int p = 0; p < PHASES; p++) begin
            hi[p] += int'(pwm.pos[p]);
            lo[p] += int'(pwm.neg[p]);
         end
      end while (crest !== 1'b1 && per < 200);
      guard(per < 200);
   endtask

   function automatic int expHi(input int d);
      if (d == 0)
         return PER;
      if (d >= M + 2)
         return M + 1;
      return PER - 2 * d;
   endfunction

   task automatic runDuty(input int du, input int dv, input int dw, input int dt);
      int d [PHASES];
      int e;
      int g;
      d = '{du, dv, dw};
      axiWrite(OFS_DEAD, 32'(dt));
      for (int p = 0; p < PHASES; p++)
         axiWrite(dutyOfs[p], 32'(d[p]));
      measure();
      measure();
      `CHK(per, PER)
      for (int p = 0; p < PHASES; p++) begin
         e = expHi(d[p]);
         g = (e != 0 && e != PER) ? dt : 0;
         `CHK(hi[p], e - g)
         `CHK(lo[p], PER - e - g)
      end
      $display("duty set %0d %0d %0d dead %0d done", du, dv, dw, dt);
   endtask

   initial begin
      reset_n <= 1'b0;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (5) @(posedge clk_sys);
      axiRead(OFS_CTRL);
      `CHK(rdData, 32'h0)
      axiRead(6'h28);
      `CHK(resp, RESP_SLVERR)
      `CHK(rdData, 32'h0)
      axiWrite(OFS_STATUS, 32'hffff_ffff);
      `CHK(resp, RESP_OKAY)
      axiWrite(OFS_CYCLE, 32'(M));
      axiRead(OFS_CYCLE);
      `CHK(rdData, 32'(M))
      axiWrite(OFS_OPT1, 32'h3);
      axiWrite(OFS_CTRL, 32'h0e);
      repeat (20) @(posedge clk_sys);
      axiRead(OFS_STATUS);
      `CHK(rdData, 32'h0)
      `CHK(pwm, 6'h0)
      $display("register test done");
      axiWrite(OFS_CTRL, 32'h1f);
      runDuty(0, M + 1, M + 2, 0);
      runDuty(1, 2, M, 0);
      runDuty(2, 3, 4, 1);
      for (int k = 0; k < 8; k++) begin
         axiRead(OFS_STATUS);
         `CHK(rdData[31:16] <= 16'(M + 1), 1'b1)
         if (rdData[31:16] == 16'h0 || rdData[31:16] == 16'(M + 1))
            `CHK(rdData[0], rdData[16])
      end
      $display("direction test done");
      axiWrite(OFS_OPT1, 32'h5);
      repeat (2 * PER) @(negedge clk_sys);
      nCrest = 0;
      nValley = 0;
      repeat (4 * PER) begin
         @(negedge clk_sys);
         nCrest += int'(crest);
         nValley += int'(valley);
      end
      `CHK(nCrest, 2)
      `CHK(nValley, 0)
      `CHK(shootThru, 0)
      $display("thinning test done");
      axiWrite(OFS_CTRL, 32'h0f);
      axiWrite(OFS_COMP0, 32'h1234);
      repeat (2 * PER) @(negedge clk_sys);
      `CHK(cmpOut[0], 16'h0)
      axiWrite(OFS_DUTY_U, 32'h1);
      repeat (PER) @(negedge clk_sys);
      `CHK(cmpOut[0], 16'h1234)
      $display("batch rewrite test done");
      printVerdict();
   end
endmodule
